/* File: lnbr_register_bank.sv */
// How it works
// - Device acknowledges its address and each written byte by holding data low through the next clock high.
// - Written data is committed on the falling clock edge of the data LSB.
// - Serial writes are acknowledged but not committed while the enable pin is low.
// - Control one bit 6 selects power-save or forced fixed-frequency switching.
// - Control one bits 4..1 hold the output level code, reset 0100b.
// - Control one bit 0 enables external double-rate tone input and output.
// - Control two bit 7 selects tone amplitude 650 or 750 mV.
// - Control two bit 6 selects short or long hiccup periods.
// - Control two bit 5 selects three or five times switch current limit scale.
// - Control two bit 4 selects 1 MHz or 500 kHz switching.
// - Control two bit 3, reset 1, enables the antenna supply output when register control is set.
// - Bypass gate follows tone transmit when auto, else the manual bit.
// - Status flags follow their conditions without any bus access.
// - Thermal shutdown or overcurrent latches fault low until status is read.
// - Status bits 6..0 report tone, linear stage, hot, shutdown, overcurrent, cable, level.
// - Target address from select pin: 0x08, 0x09, 0x10 or 0x11.
// - Seven-bit addressing only; ten-bit and general call addresses ignored.
// - With register control set, level follows the code even with enable low.
`include "lnbr_params.svh"

module lnbr_register_bank
  import lnbr_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           sclPin,
  input  wire logic           sdaIn,
  output logic                sdaOut,
  output logic                sdaOe,
  input  wire logic           enPin,
  input  wire logic [1:0]     addrSelPin,
  input  wire logic           toneTransmitting,
  input  wire lnbr_status_t   statusPins,
  output lnbr_ctrl_one_t      ctrlOne,
  output lnbr_ctrl_two_t      ctrlTwo,
  output logic                levelFromRegisters,
  output logic                supplyOutputEnable,
  output logic                bypassGateDrive,
  output logic                faultOut_b
);

  logic [3:0]     pinSync;
  logic [1:0]     addrSelS;
  lnbr_status_t   statS;
  logic           enS;
  logic           toneS;
  logic           sclS;
  logic           sdaS;
  logic           sclPrev_q;
  logic           sdaPrev_q;
  lnbr_state_t    state_q;
  lnbr_state_t    state_d;
  logic [3:0]     bitCnt_q;
  logic [3:0]     bitCnt_d;
  logic [7:0]     shift_q;
  logic [7:0]     shift_d;
  logic [7:0]     ptr_q;
  logic [7:0]     ptr_d;
  logic           sdaOe_q;
  logic           sdaOe_d;
  logic           masterAck_q;
  logic           masterAck_d;
  lnbr_ctrl_one_t ctrlOne_q;
  lnbr_ctrl_two_t ctrlTwo_q;
  logic           loadRead;

  // Pins cross into the clock domain through two flops each
  lnbr_sync #(.W(4), .RST(`LNBR_PIN_SYNC_RST)) u_pinSync (
    .clk       (clk),
    .rst_b     (rst_b),
    .rawLevel  ({enPin, toneTransmitting, sclPin, sdaIn}),
    .syncLevel (pinSync)
  );
  lnbr_sync #(.W(2), .RST(`LNBR_SEL_VCC)) u_addrSync (
    .clk       (clk),
    .rst_b     (rst_b),
    .rawLevel  (addrSelPin),
    .syncLevel (addrSelS)
  );
  // Status follows the analog conditions live, no bus access needed
  lnbr_sync #(.W(7), .RST(`LNBR_STATUS_RST)) u_statSync (
    .clk       (clk),
    .rst_b     (rst_b),
    .rawLevel  (statusPins),
    .syncLevel (statS)
  );

  assign enS   = pinSync[3];
  assign toneS = pinSync[2];
  assign sclS  = pinSync[1];
  assign sdaS  = pinSync[0];

  // Bus line events seen at the 200 MHz sample rate
  wire sclRise   = sclS & ~sclPrev_q;
  wire sclFall   = ~sclS & sclPrev_q;
  wire startSeen = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  wire stopSeen  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
  wire byteDone  = sclFall & (bitCnt_q == `LNBR_BYTE_BITS);

  // Target address from the select strap
  wire [6:0] devAddr = (addrSelS == `LNBR_SEL_VCC)   ? `LNBR_ADDR_VCC   :
                       (addrSelS == `LNBR_SEL_FLOAT) ? `LNBR_ADDR_FLOAT :
                       (addrSelS == `LNBR_SEL_GND)   ? `LNBR_ADDR_GND   :
                                                       `LNBR_ADDR_DIV;
  // General call and ten-bit headers never equal a seven-bit target address
  wire addrMatch = (shift_q[7:1] == devAddr);

  // Write decode: commit only while enabled, status is read-only
  wire wrStrobe = (state_q == ST_WDATA) & byteDone & enS;
  wire wrOne    = wrStrobe & (ptr_q == `LNBR_REG_CTRL_ONE);
  wire wrTwo    = wrStrobe & (ptr_q == `LNBR_REG_CTRL_TWO);

  // Read data selection; reserved status bit reads zero
  wire [7:0] statByte = {1'b0, statS};
  wire [7:0] readData = (ptr_q == `LNBR_REG_CTRL_ONE) ? ctrlOne_q :
                        (ptr_q == `LNBR_REG_CTRL_TWO) ? ctrlTwo_q :
                        (ptr_q == `LNBR_REG_STATUS)   ? statByte  :
                                                        `LNBR_READ_PAD;
  wire faultRelease = loadRead & (ptr_q == `LNBR_REG_STATUS);
  wire faultSet     = statS.thermalShutdownFlag | statS.overcurrentFlag;

  // Serial target sequencer
  always_comb begin
    state_d     = state_q;
    bitCnt_d    = bitCnt_q;
    shift_d     = shift_q;
    ptr_d       = ptr_q;
    sdaOe_d     = sdaOe_q;
    masterAck_d = masterAck_q;
    loadRead    = 1'b0;
    if (startSeen) begin
      state_d  = ST_ADDR;
      bitCnt_d = 4'h0;
      sdaOe_d  = 1'b0;
    end else if (stopSeen) begin
      state_d = ST_IDLE;
      sdaOe_d = 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (sclRise) begin
            shift_d  = {shift_q[6:0], sdaS};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (byteDone) begin
            sdaOe_d = 1'b1;
            if (state_q == ST_ADDR) begin
              state_d = addrMatch ? ST_ADDR_ACK : ST_IDLE;
              sdaOe_d = addrMatch;
              masterAck_d = shift_q[0]; // Direction bit kept until ack ends
            end else if (state_q == ST_REG) begin
              ptr_d   = shift_q;
              state_d = ST_REG_ACK;
            end else begin
              state_d = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
          // Ack is held low across the whole ninth clock high phase
          if (sclFall) begin
            sdaOe_d  = 1'b0;
            bitCnt_d = 4'h0;
            state_d  = ST_WDATA;
            if (state_q == ST_WDATA_ACK) begin
              ptr_d = ptr_q + 8'h01;
            end else if (state_q == ST_REG_ACK) begin
              state_d = ST_WDATA;
            end else if (masterAck_q) begin
              state_d  = ST_RDATA;
              ptr_d    = ptr_q + 8'h01; // Post-increment: a continued read fetches the next one
              loadRead = 1'b1;
              shift_d  = readData;
              sdaOe_d  = ~readData[7];
            end else begin
              state_d = ST_REG;
            end
          end
        end
        ST_RDATA: begin
          if (sclFall) begin
            bitCnt_d = bitCnt_q + 4'h1;
            shift_d  = {shift_q[6:0], 1'b0};
            sdaOe_d  = ~shift_q[6];
            if (bitCnt_q == 4'h7) begin
              sdaOe_d = 1'b0;
              state_d = ST_RDATA_ACK;
            end
          end
        end
        ST_RDATA_ACK: begin
          if (sclRise) begin
            masterAck_d = ~sdaS;
          end else if (sclFall) begin
            bitCnt_d = 4'h0;
            if (masterAck_q) begin
              state_d  = ST_RDATA;
              ptr_d    = ptr_q + 8'h01;
              loadRead = 1'b1;
              shift_d  = readData;
              sdaOe_d  = ~readData[7];
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        default: begin
          state_d = ST_IDLE;
          sdaOe_d = 1'b0;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= ST_IDLE;
      bitCnt_q    <= 4'h0;
      shift_q     <= 8'h00;
      ptr_q       <= 8'h00;
      sdaOe_q     <= 1'b0;
      masterAck_q <= 1'b0;
      sclPrev_q   <= 1'b1;
      sdaPrev_q   <= 1'b1;
    end else begin
      state_q     <= state_d;
      bitCnt_q    <= bitCnt_d;
      shift_q     <= shift_d;
      ptr_q       <= ptr_d;
      sdaOe_q     <= sdaOe_d;
      masterAck_q <= masterAck_d;
      sclPrev_q   <= sclS;
      sdaPrev_q   <= sdaS;
    end
  end

  // Control registers, written at the LSB falling edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlOne_q <= `LNBR_CTRL_ONE_RST;
      ctrlTwo_q <= `LNBR_CTRL_TWO_RST;
    end else if (wrOne) begin
      ctrlOne_q <= shift_q;
    end else if (wrTwo) begin
      ctrlTwo_q <= shift_q;
    end
  end

  lnbr_fault_latch u_fault (
    .clk          (clk),
    .rst_b        (rst_b),
    .faultSet     (faultSet),
    .faultRelease (faultRelease),
    .faultOut_b   (faultOut_b)
  );

  // Open-drain data line only ever pulls low
  assign sdaOut  = 1'b0;
  assign sdaOe   = sdaOe_q;
  assign ctrlOne = ctrlOne_q;
  assign ctrlTwo = ctrlTwo_q;

  // Register control overrides the enable pin, even when it is low
  assign levelFromRegisters = ctrlOne_q.hostControlSelect;
  assign supplyOutputEnable = ctrlOne_q.hostControlSelect ? ctrlTwo_q.supplyEnable
                                                          : enS;
  assign bypassGateDrive    = ctrlTwo_q.bypassAuto ? toneS
                                                   : ctrlTwo_q.bypassManualOn;

  property p_addr_ack;
    @(posedge clk) disable iff (!rst_b)
      (state_q == ST_ADDR && byteDone && addrMatch && !startSeen && !stopSeen)
        |=> sdaOe_q ##0 state_q == ST_ADDR_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

  property p_ack_hold;
    @(posedge clk) disable iff (!rst_b)
      (state_q == ST_WDATA_ACK && sclS && !sclFall && !stopSeen && !startSeen)
        |-> sdaOe_q;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack released during high");

  property p_commit;
    @(posedge clk) disable iff (!rst_b)
      wrOne |=> (ctrlOne_q == $past(shift_q));
  endproperty
  a_commit: assert property (p_commit) else $error("write not committed");

  property p_no_wr_disabled;
    @(posedge clk) disable iff (!rst_b)
      !enS |=> $stable(ctrlOne_q) && $stable(ctrlTwo_q);
  endproperty
  a_no_wr_disabled: assert property (p_no_wr_disabled) else $error("write while off");

  property p_status_ro;
    @(posedge clk) disable iff (!rst_b)
      (wrStrobe && ptr_q == `LNBR_REG_STATUS) |=> $stable(ctrlOne_q) && $stable(ctrlTwo_q);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write changed control");

  property p_reg_ctrl;
    @(posedge clk) disable iff (!rst_b)
      (ctrlOne_q.hostControlSelect && !enS) |-> supplyOutputEnable == ctrlTwo_q.supplyEnable;
  endproperty
  a_reg_ctrl: assert property (p_reg_ctrl) else $error("level ignores registers");

  property p_fault_set;
    @(posedge clk) disable iff (!rst_b)
      faultSet |=> !faultOut_b ##1 (!faultOut_b || $past(faultRelease));
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");

  property p_fault_hold;
    @(posedge clk) disable iff (!rst_b)
      (!faultOut_b && !faultRelease) |=> !faultOut_b;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault released early");

  property p_bypass;
    @(posedge clk) disable iff (!rst_b)
      (!ctrlTwo_q.bypassAuto && $changed(ctrlTwo_q.bypassManualOn))
        |-> bypassGateDrive == ctrlTwo_q.bypassManualOn;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass gate wrong");

  property p_addr_ignore;
    @(posedge clk) disable iff (!rst_b)
      (state_q == ST_ADDR && byteDone && !addrMatch && !startSeen && !stopSeen)
        |=> state_q == ST_IDLE && !sdaOe_q;
  endproperty
  a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address taken");

endmodule // lnbr_register_bank

/* File: lnbr_params.svh */
`ifndef LNBR_PARAMS_SVH
`define LNBR_PARAMS_SVH

// Register offsets
`define LNBR_REG_CTRL_ONE      8'h00
`define LNBR_REG_CTRL_TWO      8'h01
`define LNBR_REG_STATUS        8'h02

// Reset values
`define LNBR_CTRL_ONE_RST      8'h08
`define LNBR_CTRL_TWO_RST      8'h09
`define LNBR_STATUS_RST        7'h29
`define LNBR_PIN_SYNC_RST      4'h3

// Target addresses chosen by the address-select code
`define LNBR_SEL_VCC           2'h0
`define LNBR_SEL_FLOAT         2'h1
`define LNBR_SEL_GND           2'h2
`define LNBR_ADDR_VCC          7'h08
`define LNBR_ADDR_FLOAT        7'h09
`define LNBR_ADDR_GND          7'h10
`define LNBR_ADDR_DIV          7'h11

// Bit count of one serial byte, and the byte read back from unused offsets
`define LNBR_BYTE_BITS         4'h8
`define LNBR_READ_PAD          8'h00

`endif

/* File: lnbr_pkg.sv */
package lnbr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } lnbr_state_t;

  typedef struct packed {
    logic       hostControlSelect;
    logic       forcedSwitchingSelect;
    logic       reservedFive;
    logic [3:0] outputLevelCode;
    logic       extDoubleToneEnable;
  } lnbr_ctrl_one_t;

  typedef struct packed {
    logic toneAmplitudeSelect;
    logic hiccupLongSelect;
    logic switchLimitFiveSelect;
    logic switchFreqSelect;
    logic supplyEnable;
    logic detectOutputMode;
    logic bypassAuto;
    logic bypassManualOn;
  } lnbr_ctrl_two_t;

  typedef struct packed {
    logic toneDetectInRange;
    logic linearStageOn;
    logic hotDieWarning;
    logic thermalShutdownFlag;
    logic overcurrentFlag;
    logic cableConnected;
    logic outputInRange;
  } lnbr_status_t;

endpackage

/* File: lnbr_sync.sv */
// Two-stage synchroniser for levels from outside the clock domain
module lnbr_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] rawLevel,
  output logic      [W-1:0] syncLevel
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q    <= RST;
      syncLevel <= RST;
    end else begin
      meta_q    <= rawLevel;
      syncLevel <= meta_q;
    end
  end

endmodule // lnbr_sync

/* File: lnbr_fault_latch.sv */
// Latched fault output, released by a read of the status register
module lnbr_fault_latch (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic faultSet,
  input  wire logic faultRelease,
  output logic      faultOut_b
);

  // Set wins over release so a fault still present is not lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      faultOut_b <= 1'b0;
    end else if (faultSet) begin
      faultOut_b <= 1'b0;
    end else if (faultRelease) begin
      faultOut_b <= 1'b1;
    end
  end

endmodule // lnbr_fault_latch

/* File: lnbr_bus_master.sv */
// Bus controller model: makes the serial clock, drives data, samples the wire
module lnbr_bus_master (
  input  wire logic clk,
  input  wire logic sdaWire,
  output logic      sclPin,
  output logic      sdaDrive
);
  timeunit 1ns;
  timeprecision 1ps;

  int slowExtra = 0; // Stretched low phase, as a slow controller would

  // Idle bus: both lines released to the pull-ups
  initial begin
    sclPin = 1'b1;
    sdaDrive = 1'b1;
  end

  // Every bus edge is paced by the system clock, so edges never race it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One bit, 125 ns plus 5 ns per slowExtra cycle; data moves only while the bus clock is low
  task automatic bitCycle(input logic b, output logic seen);
    sdaDrive <= b;
    tick(6);
    sclPin <= 1'b1;
    tick(7);
    seen = sdaWire; // Mid high phase, well after the device settles
    tick(6);
    sclPin <= 1'b0;
    tick(6 + slowExtra);
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx,
                      output logic ackIn);
    for (int i = 7; i >= 0; i--) begin
      bitCycle(tx[i], rx[i]);
    end
    bitCycle(ackOut, ackIn);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start;
    sdaDrive <= 1'b1;
    tick(6);
    sclPin <= 1'b1;
    tick(6);
    sdaDrive <= 1'b0;
    tick(6);
    sclPin <= 1'b0;
    tick(6);
  endtask

  // Stop: data rises while the clock is high, then the bus idles
  task automatic stop;
    sdaDrive <= 1'b0;
    tick(6);
    sclPin <= 1'b1;
    tick(6);
    sdaDrive <= 1'b1;
    tick(12);
  endtask

  // Single update: address, register byte, data byte
  task automatic writeReg(input logic [6:0] dev, input logic [7:0] regAddr,
                          input logic [7:0] data, output logic [2:0] acks);
    logic [7:0] rx;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, acks[2]);
    xfer(regAddr, 1'b1, rx, acks[1]);
    xfer(data, 1'b1, rx, acks[0]);
    stop();
  endtask

  // Pointer write, repeated start, one byte read and not acknowledged
  task automatic readReg(input logic [6:0] dev, input logic [7:0] regAddr,
                         output logic [7:0] data, output logic [2:0] acks);
    logic [7:0] rx;
    logic       nack;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, acks[2]);
    xfer(regAddr, 1'b1, rx, acks[1]);
    start();
    xfer({dev, 1'b1}, 1'b1, rx, acks[0]);
    xfer(8'hFF, 1'b1, data, nack);
    stop();
  endtask

  // Continued read: first byte acknowledged by the controller, second not
  task automatic readPair(input logic [6:0] dev, input logic [7:0] regAddr,
                          output logic [15:0] data, output logic [2:0] acks);
    logic [7:0] rx;
    logic       ackSeen;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, acks[2]);
    xfer(regAddr, 1'b1, rx, acks[1]);
    start();
    xfer({dev, 1'b1}, 1'b1, rx, acks[0]);
    xfer(8'hFF, 1'b0, data[15:8], ackSeen);
    xfer(8'hFF, 1'b1, data[7:0], ackSeen);
    stop();
  endtask
endmodule // lnbr_bus_master

/* File: tb_lnb_supply_i2c_register_bank.sv */
module tb_lnb_supply_i2c_register_bank import lnbr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic           clk;
  logic           rst_b;
  logic           sclPin;
  logic           sdaDrive;
  logic           sdaOut;
  logic           sdaOe;
  logic           enPin;
  logic [1:0]     addrSelPin;
  logic           toneTransmitting;
  lnbr_status_t   statusPins;
  lnbr_ctrl_one_t ctrlOne;
  lnbr_ctrl_two_t ctrlTwo;
  logic           levelFromRegisters;
  logic           supplyOutputEnable;
  logic           bypassGateDrive;
  logic           faultOut_b;
  logic [7:0]     expOne = 8'h08;
  logic [7:0]     expTwo = 8'h09;
  logic [31:0]    seed = 32'h05BD;
  logic [6:0]     bad [3] = '{7'h00, 7'h7A, 7'h09};
  int             nErrors = 0;
  int             comparisons = 0;
  int             cycles = 0;
  wire            sdaWire = sdaDrive & (sdaOe ? sdaOut : 1'b1); // Open drain, pull-up

  // System clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  lnbr_register_bank i_lnbr_register_bank (
    .clk(clk), .rst_b(rst_b), .sclPin(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .enPin(enPin), .addrSelPin(addrSelPin),
    .toneTransmitting(toneTransmitting), .statusPins(statusPins), .ctrlOne(ctrlOne),
    .ctrlTwo(ctrlTwo), .levelFromRegisters(levelFromRegisters),
    .supplyOutputEnable(supplyOutputEnable), .bypassGateDrive(bypassGateDrive),
    .faultOut_b(faultOut_b)
  );

  lnbr_bus_master i_lnbr_bus_master (
    .clk(clk), .sdaWire(sdaWire), .sclPin(sclPin), .sdaDrive(sdaDrive)
  );

  // Verdict, reached from the main sequence or the hang guard
  task automatic conclude;
    if (nErrors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, about one and a half times the expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      nErrors = nErrors + 1;
      conclude();
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  function automatic logic [31:0] nextRand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Target address for each strap code
  function automatic logic [6:0] devAddr(input logic [1:0] sel);
    case (sel)
      2'h0: return 7'h08;
      2'h1: return 7'h09;
      2'h2: return 7'h10;
      default: return 7'h11;
    endcase
  endfunction

  // Pins change at an edge, then settle through the synchronisers
  task automatic drivePins(input logic [31:0] r);
    @(posedge clk);
    enPin            <= r[0];
    toneTransmitting <= r[1];
    addrSelPin       <= r[3:2];
    statusPins       <= r[14:8];
    repeat (6) @(posedge clk);
  endtask

  // Write with every byte acknowledged; registers move only while enabled
  task automatic wr(input logic [7:0] regAddr, input logic [7:0] data);
    logic [2:0] acks;
    i_lnbr_bus_master.writeReg(devAddr(addrSelPin), regAddr, data, acks);
    chk8("write acks", 8'h00, {5'h00, acks});
    if (enPin === 1'b1 && regAddr === 8'h00) expOne = data;
    if (enPin === 1'b1 && regAddr === 8'h01) expTwo = data;
  endtask

  task automatic rdChk(input logic [7:0] regAddr, input logic [7:0] exp);
    logic [2:0] acks;
    logic [7:0] got;
    i_lnbr_bus_master.readReg(devAddr(addrSelPin), regAddr, got, acks);
    chk8("read acks", 8'h00, {5'h00, acks});
    chk8("read data", exp, got);
  endtask

  task automatic checkOutputs;
    chk8("ctrlOne", expOne, ctrlOne);
    chk8("ctrlTwo", expTwo, ctrlTwo);
    chk8("level code", {4'h0, expOne[4:1]}, {4'h0, ctrlOne.outputLevelCode});
    chk1("levelFromRegisters", expOne[7], levelFromRegisters);
    chk1("supplyOutputEnable", expOne[7] ? expTwo[3] : enPin, supplyOutputEnable);
    chk1("bypassGateDrive", expTwo[1] ? toneTransmitting : expTwo[0], bypassGateDrive);
  endtask

  initial begin
    logic [31:0] r;
    logic [7:0]  data;
    logic [2:0]  acks;
    logic [15:0] pair;
    rst_b = 1'b0;
    enPin = 1'b0;
    toneTransmitting = 1'b0;
    addrSelPin = 2'h0;
    statusPins = 7'h00;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    checkOutputs();
    chk1("faultOut_b", 1'b0, faultOut_b);
    // Fault latch: cleared by a read, set by each flag, held after it goes
    drivePins(32'h0000_0001);
    rdChk(8'h02, 8'h00);
    chk1("faultOut_b", 1'b1, faultOut_b);
    for (int f = 10; f < 12; f++) begin
      drivePins((32'h1 << f) | 32'h1);
      chk1("faultOut_b", 1'b0, faultOut_b);
      rdChk(8'h02, 8'h1 << (f - 8));
      drivePins(32'h0000_0001);
      chk1("faultOut_b", 1'b0, faultOut_b);
      rdChk(8'h02, 8'h00);
      chk1("faultOut_b", 1'b1, faultOut_b);
    end
    rdChk(8'h00, 8'h08);
    rdChk(8'h01, 8'h09);
    // Continued read steps the pointer to the next register
    i_lnbr_bus_master.readPair(devAddr(addrSelPin), 8'h00, pair, acks);
    chk8("pair acks", 8'h00, {5'h00, acks});
    chk8("pair first", 8'h08, pair[15:8]);
    chk8("pair second", 8'h09, pair[7:0]);
    // Foreign, general call and ten-bit header addresses get no acknowledge
    foreach (bad[i]) begin
      i_lnbr_bus_master.writeReg(bad[i], 8'h00, 8'hFF, acks);
      chk1("address ack", 1'b1, acks[2]);
    end
    checkOutputs();
    wr(8'h02, 8'hFF);
    rdChk(8'h02, {1'b0, statusPins});
    rdChk(8'h03, 8'h00);
    // Register control keeps the output up with the enable pin low
    wr(8'h00, 8'h9E);
    wr(8'h01, 8'h08);
    drivePins(32'h0000_0000);
    checkOutputs();
    wr(8'h00, 8'h00);
    checkOutputs();
    // Random traffic over straps, pins, registers and controller speed
    for (int k = 0; k < 12; k++) begin
      r = nextRand();
      drivePins(r & 32'hFFFF_F3FF);
      i_lnbr_bus_master.slowExtra = r[20] ? 20 : 0;
      data = r[31:24];
      if (r[16]) data[2] = 1'b0;
      wr({7'h00, r[16]}, data);
      checkOutputs();
      rdChk({7'h00, r[16]}, r[16] ? expTwo : expOne);
      rdChk(8'h02, {1'b0, statusPins});
    end
    conclude();
  end
endmodule // tb_lnb_supply_i2c_register_bank
